// ### common/ctfm_defines.vh
// Constants of the current and temperature fault monitor.
// Assumes inclusion by bare name from the logic files.
`ifndef CTFM_DEFINES_VH
`define CTFM_DEFINES_VH
// Command codes of the limit and action registers
`define CTFM_CMD_OC_LIM     8'h46
`define CTFM_CMD_UC_LIM     8'h4b
`define CTFM_CMD_OTF_LIM    8'h4f
`define CTFM_CMD_OT_ACT     8'h50
`define CTFM_CMD_OTW_LIM    8'h51
`define CTFM_CMD_UTW_LIM    8'h52
`define CTFM_CMD_UTF_LIM    8'h53
`define CTFM_CMD_UT_ACT     8'h54
// Reset values
`define CTFM_RST_OC_LIM     16'he200
`define CTFM_RST_UC_LIM     16'he600
`define CTFM_RST_OTF_LIM    16'hebe8
`define CTFM_RST_OTW_LIM    16'heb70
`define CTFM_RST_UTW_LIM    16'he4e0
`define CTFM_RST_UTF_LIM    16'he490
`define CTFM_RST_ACT        8'h80
// Action byte fields
`define CTFM_ACT_MODE_HI    7
`define CTFM_ACT_MODE_LO    6
`define CTFM_ACT_RTRY_HI    5
`define CTFM_ACT_RTRY_LO    3
`define CTFM_ACT_DLY_HI     2
`define CTFM_ACT_DLY_LO     0
// Response modes
`define CTFM_MODE_IGNORE    2'h0
`define CTFM_MODE_DELAY     2'h1
`define CTFM_MODE_DISABLE   2'h2
`define CTFM_MODE_HOLD      2'h3
`define CTFM_RTRY_NONE      3'h0
`define CTFM_RTRY_FOREVER   3'h7
// Limit word layout: exponent 15:11, mantissa 10:0
`define CTFM_L11_EXP_HI     15
`define CTFM_L11_EXP_LO     11
`define CTFM_L11_MAN_HI     10
// Fraction bits of measurement inputs
`define CTFM_MEAS_FRAC      6'h04
// Timing
`define CTFM_CLK_NS         40
`define CTFM_DELAY_UNIT_NS  1000000
`endif

// ### logic/ctfm_response.v
// Fault response sequencer for one fault source.
// Assumes a one-cycle delay unit tick and a same-clock fault level.
`timescale 1ns/1ns
`include "ctfm_defines.vh"
module ctfm_response (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       rst_n,
   // Control
   input  wire [7:0] action,
   input  wire       fault,
   input  wire       tick,
   input  wire       restart,
   // Status
   output wire       out_off,
   output wire       locked
);
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_DLY  = 5'h02;
   localparam [4:0] ST_WAIT = 5'h04;
   localparam [4:0] ST_HOLD = 5'h08;
   localparam [4:0] ST_LOCK = 5'h10;

   wire [1:0] mode = action[`CTFM_ACT_MODE_HI:`CTFM_ACT_MODE_LO];
   wire [2:0] rtry = action[`CTFM_ACT_RTRY_HI:`CTFM_ACT_RTRY_LO];
   wire [2:0] dly  = action[`CTFM_ACT_DLY_HI:`CTFM_ACT_DLY_LO];

   reg  [4:0] state_r;
   reg  [4:0] state_nxt;
   reg  [2:0] cnt_r;
   reg  [2:0] cnt_nxt;
   reg  [2:0] left_r;
   reg  [2:0] left_nxt;
   reg        off_r;

   assign out_off = off_r;
   assign locked  = state_r[4];

   always @* begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      left_nxt  = left_r;
      case (state_r)
         ST_IDLE: begin
            if (!fault) begin
               left_nxt = rtry;
            end else begin
               case (mode)
                  `CTFM_MODE_DELAY: begin
                     state_nxt = ST_DLY;
                     cnt_nxt   = dly;
                  end
                  `CTFM_MODE_DISABLE: begin
                     cnt_nxt = dly;
                     if (rtry == `CTFM_RTRY_NONE || left_r == 3'h0) begin
                        state_nxt = ST_LOCK;
                     end else begin
                        state_nxt = ST_WAIT;
                     end
                  end
                  `CTFM_MODE_HOLD: begin
                     state_nxt = ST_HOLD;
                  end
                  default: begin
                     state_nxt = ST_IDLE;
                  end
               endcase
            end
         end
         ST_DLY: begin
            if (cnt_r == 3'h0) begin
               cnt_nxt = dly;
               if (rtry == `CTFM_RTRY_NONE || left_r == 3'h0) begin
                  state_nxt = ST_LOCK;
               end else begin
                  state_nxt = ST_WAIT;
               end
            end else if (tick) begin
               cnt_nxt = cnt_r - 3'h1;
            end
         end
         ST_WAIT: begin
            if (cnt_r == 3'h0) begin
               // Restart without looking at the fault; IDLE re-trips if it is still there
               state_nxt = ST_IDLE;
               if (rtry != `CTFM_RTRY_FOREVER) begin
                  left_nxt = left_r - 3'h1;
               end
            end else if (tick) begin
               cnt_nxt = cnt_r - 3'h1;
            end
         end
         ST_HOLD: begin
            if (!fault) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_LOCK: begin
            state_nxt = ST_LOCK;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (restart) begin
         state_nxt = ST_IDLE;
         left_nxt  = rtry;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         cnt_r   <= 3'h0;
         left_r  <= 3'h0;
         off_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         left_r  <= left_nxt;
         off_r   <= ~(state_nxt[0] | state_nxt[1]);
      end
   end
endmodule

// ### logic/ctfm_monitor.v
// Current and temperature fault monitor with command-coded limit registers.
// Assumes a command decoder, sample sources and restart logic on clk_sys.
`timescale 1ns/1ns
`include "ctfm_defines.vh"
module ctfm_monitor #(
   parameter CNT_W          = 4,
   parameter DELAY_UNIT_CYC = `CTFM_DELAY_UNIT_NS / `CTFM_CLK_NS
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             rst_n,
   // Command port
   input  wire             cmd_wr,
   input  wire             cmd_rd,
   input  wire [7:0]       cmd_code,
   input  wire [15:0]      cmd_wdata,
   input  wire             clear_faults,
   output reg  [15:0]      cmd_rdata_r,
   output reg              cmd_rvalid_r,
   output reg              cmd_unsup_r,
   // Current samples
   input  wire             cur_stb,
   input  wire [15:0]      cur_val,
   input  wire             blank_done,
   input  wire [CNT_W-1:0] sample_count_cfg,
   // Temperature samples
   input  wire             tmp_stb,
   input  wire [15:0]      tmp_val,
   // Power stage control
   input  wire             dev_restart,
   output wire             output_off,
   output wire             retry_locked,
   // Status
   output reg              oc_fault_r,
   output reg              uc_fault_r,
   output reg              ot_fault_r,
   output reg              ut_fault_r,
   output reg  [6:0]       status_r,
   output reg              alert_n_r
);
   // Status bit positions
   localparam ST_OC   = 0;
   localparam ST_UC   = 1;
   localparam ST_OTF  = 2;
   localparam ST_UTF  = 3;
   localparam ST_OTW  = 4;
   localparam ST_UTW  = 5;
   localparam ST_TEMP = 6;
   // Cut to the tick counter width on purpose; the unit must not exceed 65536 cycles
   localparam integer TICK_LAST_I = DELAY_UNIT_CYC - 1;
   localparam [15:0]  TICK_LAST   = TICK_LAST_I[15:0];

   // Reset release
   reg        rst_a_r;
   reg        rst_s_n;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_a_r <= 1'b0;
         rst_s_n <= 1'b0;
      end else begin
         rst_a_r <= 1'b1;
         rst_s_n <= rst_a_r;
      end
   end

   // Limit and action registers
   reg [15:0] oc_lim_r;
   reg [15:0] uc_lim_r;
   reg [15:0] otf_lim_r;
   reg [15:0] otw_lim_r;
   reg [15:0] utw_lim_r;
   reg [15:0] utf_lim_r;
   reg [7:0]  ot_act_r;
   reg [7:0]  ut_act_r;
   reg        hit;
   reg [15:0] rdata;

   always @* begin
      hit   = 1'b1;
      rdata = 16'h0000;
      case (cmd_code)
         `CTFM_CMD_OC_LIM:  rdata = oc_lim_r;
         `CTFM_CMD_UC_LIM:  rdata = uc_lim_r;
         `CTFM_CMD_OTF_LIM: rdata = otf_lim_r;
         `CTFM_CMD_OT_ACT:  rdata = {8'h00, ot_act_r};
         `CTFM_CMD_OTW_LIM: rdata = otw_lim_r;
         `CTFM_CMD_UTW_LIM: rdata = utw_lim_r;
         `CTFM_CMD_UTF_LIM: rdata = utf_lim_r;
         `CTFM_CMD_UT_ACT:  rdata = {8'h00, ut_act_r};
         default:           hit   = 1'b0;
      endcase
   end

   always @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) begin
         oc_lim_r     <= `CTFM_RST_OC_LIM;
         uc_lim_r     <= `CTFM_RST_UC_LIM;
         otf_lim_r    <= `CTFM_RST_OTF_LIM;
         otw_lim_r    <= `CTFM_RST_OTW_LIM;
         utw_lim_r    <= `CTFM_RST_UTW_LIM;
         utf_lim_r    <= `CTFM_RST_UTF_LIM;
         ot_act_r     <= `CTFM_RST_ACT;
         ut_act_r     <= `CTFM_RST_ACT;
         cmd_rdata_r  <= 16'h0000;
         cmd_rvalid_r <= 1'b0;
         cmd_unsup_r  <= 1'b0;
      end else begin
         cmd_rvalid_r <= cmd_rd & hit;
         cmd_unsup_r  <= (cmd_rd | cmd_wr) & ~hit;
         if (cmd_rd && hit) begin
            cmd_rdata_r <= rdata;
         end
         if (cmd_wr) begin
            case (cmd_code)
               `CTFM_CMD_OC_LIM:  oc_lim_r  <= cmd_wdata;
               `CTFM_CMD_UC_LIM:  uc_lim_r  <= cmd_wdata;
               `CTFM_CMD_OTF_LIM: otf_lim_r <= cmd_wdata;
               `CTFM_CMD_OT_ACT:  ot_act_r  <= cmd_wdata[7:0];
               `CTFM_CMD_OTW_LIM: otw_lim_r <= cmd_wdata;
               `CTFM_CMD_UTW_LIM: utw_lim_r <= cmd_wdata;
               `CTFM_CMD_UTF_LIM: utf_lim_r <= cmd_wdata;
               `CTFM_CMD_UT_ACT:  ut_act_r  <= cmd_wdata[7:0];
               default:           ;
            endcase
         end
      end
   end

   // Limit word to measurement scale; left shifts cannot overflow 32 bits
   function signed [31:0] l11_dec;
      input [15:0] w;
      reg   [5:0]  e;
      reg   [5:0]  sh;
      reg   signed [31:0] m;
      begin
         e  = {w[`CTFM_L11_EXP_HI], w[`CTFM_L11_EXP_HI:`CTFM_L11_EXP_LO]}
              + `CTFM_MEAS_FRAC;
         sh = e[5] ? (6'h00 - e) : e;
         m  = {{21{w[`CTFM_L11_MAN_HI]}}, w[`CTFM_L11_MAN_HI:0]};
         l11_dec = e[5] ? (m >>> sh) : (m <<< sh);
      end
   endfunction

   function signed [31:0] sext;
      input [15:0] v;
      begin
         sext = {{16{v[15]}}, v};
      end
   endfunction

   wire signed [31:0] cur_s   = sext(cur_val);
   wire signed [31:0] tmp_s   = sext(tmp_val);
   wire signed [31:0] oc_lim  = l11_dec(oc_lim_r);
   wire signed [31:0] uc_lim  = l11_dec(uc_lim_r);
   wire signed [31:0] otf_lim = l11_dec(otf_lim_r);
   wire signed [31:0] otw_lim = l11_dec(otw_lim_r);
   wire signed [31:0] utw_lim = l11_dec(utw_lim_r);
   wire signed [31:0] utf_lim = l11_dec(utf_lim_r);

   // Current checks; a zero count setting behaves as one sample
   wire             cur_ok   = cur_stb & blank_done;
   wire             oc_over  = cur_s > oc_lim;
   wire             uc_under = cur_s < uc_lim;
   wire [CNT_W-1:0] need     = (sample_count_cfg == {CNT_W{1'b0}}) ?
                               {{(CNT_W-1){1'b0}}, 1'b1} : sample_count_cfg;
   reg  [CNT_W-1:0] oc_cnt_r;
   reg  [CNT_W-1:0] uc_cnt_r;
   wire             oc_hit   = cur_ok & oc_over & (oc_cnt_r >= need - 1'b1);
   wire             uc_hit   = cur_ok & uc_under & (uc_cnt_r >= need - 1'b1);

   always @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) begin
         oc_cnt_r   <= {CNT_W{1'b0}};
         uc_cnt_r   <= {CNT_W{1'b0}};
         oc_fault_r <= 1'b0;
         uc_fault_r <= 1'b0;
      end else if (cur_ok) begin
         // Any good sample breaks the run
         if (!oc_over) begin
            oc_cnt_r <= {CNT_W{1'b0}};
         end else if (oc_cnt_r != {CNT_W{1'b1}}) begin
            oc_cnt_r <= oc_cnt_r + 1'b1;
         end
         if (!uc_under) begin
            uc_cnt_r <= {CNT_W{1'b0}};
         end else if (uc_cnt_r != {CNT_W{1'b1}}) begin
            uc_cnt_r <= uc_cnt_r + 1'b1;
         end
         oc_fault_r <= oc_hit;
         uc_fault_r <= uc_hit;
      end
   end

   // Temperature checks with hysteresis
   wire ot_set  = tmp_stb & (tmp_s > otf_lim);
   wire ut_set  = tmp_stb & (tmp_s < utf_lim);
   wire otw_now = tmp_s > otw_lim;
   wire utw_now = tmp_s < utw_lim;
   reg  otw_r;
   reg  utw_r;

   always @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) begin
         ot_fault_r <= 1'b0;
         ut_fault_r <= 1'b0;
         otw_r      <= 1'b0;
         utw_r      <= 1'b0;
      end else if (tmp_stb) begin
         otw_r <= otw_now;
         utw_r <= utw_now;
         if (ot_set) begin
            ot_fault_r <= 1'b1;
         end else if (tmp_s < otw_lim) begin
            ot_fault_r <= 1'b0;
         end
         if (ut_set) begin
            ut_fault_r <= 1'b1;
         end else if (tmp_s > utw_lim) begin
            ut_fault_r <= 1'b0;
         end
      end
   end

   // Sticky status; an event in the clearing cycle survives
   wire [6:0] st_set;
   assign st_set[ST_OC]   = oc_hit;
   assign st_set[ST_UC]   = uc_hit;
   assign st_set[ST_OTF]  = ot_set;
   assign st_set[ST_UTF]  = ut_set;
   assign st_set[ST_OTW]  = tmp_stb & otw_now;
   assign st_set[ST_UTW]  = tmp_stb & utw_now;
   assign st_set[ST_TEMP] = |st_set[ST_UTW:ST_OTF];

   wire [6:0] st_nxt = (clear_faults ? 7'h00 : status_r) | st_set;

   always @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) begin
         status_r  <= 7'h00;
         alert_n_r <= 1'b1;
      end else begin
         status_r  <= st_nxt;
         alert_n_r <= ~(|st_nxt);
      end
   end

   // Shared delay unit tick
   reg [15:0] tick_cnt_r;
   reg        tick_r;
   always @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) begin
         tick_cnt_r <= 16'h0000;
         tick_r     <= 1'b0;
      end else begin
         tick_r <= (tick_cnt_r == TICK_LAST);
         if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_r <= 16'h0000;
         end else begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
         end
      end
   end

   // Fault responses; the delay may start mid-unit, so it can end up to one unit early
   wire ot_off;
   wire ut_off;
   wire ot_lock;
   wire ut_lock;

   ctfm_response u_ot_resp (
      .clk_sys (clk_sys),
      .rst_n   (rst_s_n),
      .action  (ot_act_r),
      .fault   (ot_fault_r),
      .tick    (tick_r),
      .restart (dev_restart),
      .out_off (ot_off),
      .locked  (ot_lock)
   );

   ctfm_response u_ut_resp (
      .clk_sys (clk_sys),
      .rst_n   (rst_s_n),
      .action  (ut_act_r),
      .fault   (ut_fault_r),
      .tick    (tick_r),
      .restart (dev_restart),
      .out_off (ut_off),
      .locked  (ut_lock)
   );

   assign output_off   = ot_off | ut_off;
   assign retry_locked = ot_lock | ut_lock;

endmodule

// ### tb/ctfm_monitor_properties.sv
// Port-level checker of the current and temperature fault monitor.
// Assumes it is bound to ctfm_monitor and sees only that module's ports.
`timescale 1ns/1ns
module ctfm_monitor_properties (
   // Clock and reset
   input wire        clk_sys,
   input wire        rst_n,
   // Command port
   input wire        cmd_rd,
   input wire [7:0]  cmd_code,
   input wire        clear_faults,
   input wire [15:0] cmd_rdata_r,
   input wire        cmd_rvalid_r,
   input wire        cmd_unsup_r,
   // Samples and control
   input wire        cur_stb,
   input wire        blank_done,
   input wire        tmp_stb,
   input wire        dev_restart,
   // Status
   input wire        retry_locked,
   input wire        oc_fault_r,
   input wire        uc_fault_r,
   input wire        ot_fault_r,
   input wire [6:0]  status_r,
   input wire        alert_n_r
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   wire code_ok = cmd_code inside {8'h46, 8'h4b, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54};
   wire vcur    = cur_stb && blank_done;
   sequence mapped_rd;
      cmd_rd && code_ok;
   endsequence
   // A read right after another read may legally move rdata, so only lone ones count
   sequence lone_bad_rd;
      cmd_rd && !code_ok && !$past(cmd_rd);
   endsequence
   sequence blank_smp;
      cur_stb && !blank_done;
   endsequence
   read_answer_a: assert property (mapped_rd |=> cmd_rvalid_r && !cmd_unsup_r)
      else $error("Mapped read got no answer");
   unmapped_read_a: assert property (lone_bad_rd |=> cmd_unsup_r && !cmd_rvalid_r
      && $stable(cmd_rdata_r)) else $error("Unmapped read not refused");
   blank_ignore_a: assert property (blank_smp |=> $stable(oc_fault_r) && $stable(uc_fault_r))
      else $error("Blanked sample changed a current fault");
   oc_cause_a: assert property ($rose(oc_fault_r) |-> $past(vcur))
      else $error("Overcurrent fault without a valid sample");
   sticky_status_a: assert property (!clear_faults |=>
      (status_r & $past(status_r)) == $past(status_r)) else $error("Status bit lost");
   summary_bit_a: assert property (|status_r[5:2] |-> status_r[6])
      else $error("Temperature summary bit missing");
   alert_level_a: assert property (|status_r |-> ##[0:1] !alert_n_r)
      else $error("Host not alerted");
   ot_status_a: assert property ($rose(ot_fault_r) |-> status_r[2] && $past(tmp_stb))
      else $error("Overtemperature fault without status or sample");
   ot_hold_a: assert property (ot_fault_r && !tmp_stb |=> ot_fault_r)
      else $error("Overtemperature fault dropped without a sample");
   restart_run_a: assert property (dev_restart |=> !retry_locked)
      else $error("Restart left the sequencer latched");
endmodule
bind ctfm_monitor ctfm_monitor_properties i_props (
   .clk_sys(clk_sys), .rst_n(rst_n), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
   .clear_faults(clear_faults), .cmd_rdata_r(cmd_rdata_r), .cmd_rvalid_r(cmd_rvalid_r),
   .cmd_unsup_r(cmd_unsup_r), .cur_stb(cur_stb), .blank_done(blank_done), .tmp_stb(tmp_stb),
   .dev_restart(dev_restart), .retry_locked(retry_locked), .oc_fault_r(oc_fault_r),
   .uc_fault_r(uc_fault_r), .ot_fault_r(ot_fault_r), .status_r(status_r),
   .alert_n_r(alert_n_r)
);

// ### tb/ctfm_host_model.sv
// Host controller model issuing limit commands and clear-faults.
// Assumes the monitor's command port on the same clk_sys.
`timescale 1ns/1ns
module ctfm_host_model (
   // Clock
   input  wire        clk_sys,
   // Requests
   output logic       cmd_wr,
   output logic       cmd_rd,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   output logic       clear_faults,
   // Answers
   input  wire [15:0] cmd_rdata_r,
   input  wire        cmd_rvalid_r,
   input  wire        cmd_unsup_r
);
   initial begin
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
      clear_faults = 1'b0;
   end
   // Word write; the data is scrambled afterwards so stale data never passes
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk_sys);
      cmd_wr <= 1'b1;
      cmd_code <= c;
      cmd_wdata <= d;
      @(posedge clk_sys);
      cmd_wr <= 1'b0;
      cmd_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
      int n;
      @(posedge clk_sys);
      cmd_rd <= 1'b1;
      cmd_code <= c;
      @(posedge clk_sys);
      cmd_rd <= 1'b0;
      #1;
      n = 0;
      while (cmd_rvalid_r !== 1'b1 && cmd_unsup_r !== 1'b1 && n < 4) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      d = cmd_rdata_r;
      ok = cmd_rvalid_r;
   endtask
   task automatic clear;
      @(posedge clk_sys);
      clear_faults <= 1'b1;
      @(posedge clk_sys);
      clear_faults <= 1'b0;
      #1;
   endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench of the fault monitor with a host model.
// Assumes a 25 MHz clk_sys and a shortened delay unit of four cycles.
`timescale 1ns/1ns
module testbench;
   localparam int UNIT = 4;
   typedef struct {logic [7:0] code; logic [15:0] rst; logic [15:0] wv;} ctfm_row_t;
   ctfm_row_t   rows [8] = '{'{8'h46, 16'he200, 16'h1234}, '{8'h4b, 16'he600, 16'ha5a5},
      '{8'h4f, 16'hebe8, 16'h5a5a}, '{8'h50, 16'h0080, 16'h12c3}, '{8'h51, 16'heb70, 16'hffff},
      '{8'h52, 16'he4e0, 16'h0001}, '{8'h53, 16'he490, 16'h8000}, '{8'h54, 16'h0080, 16'h003c}};
   logic        clk_sys, rst_n, cur_stb, blank_done, tmp_stb, dev_restart, rd_ok;
   logic [15:0] cur_val, tmp_val, rd_d, ex;
   logic [3:0]  sample_count_cfg;
   wire         cmd_wr, cmd_rd, clear_faults, cmd_rvalid_r, cmd_unsup_r;
   wire         output_off, retry_locked, oc_fault_r, uc_fault_r, ot_fault_r, ut_fault_r;
   wire         alert_n_r;
   wire [7:0]   cmd_code;
   wire [15:0]  cmd_wdata, cmd_rdata_r;
   wire [6:0]   status_r;
   int          fail_count, num_checks, n;
   ctfm_monitor #(.CNT_W(4), .DELAY_UNIT_CYC(UNIT)) i_ctfm_monitor (.clk_sys(clk_sys),
      .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .clear_faults(clear_faults), .cmd_rdata_r(cmd_rdata_r),
      .cmd_rvalid_r(cmd_rvalid_r), .cmd_unsup_r(cmd_unsup_r), .cur_stb(cur_stb),
      .cur_val(cur_val), .blank_done(blank_done), .sample_count_cfg(sample_count_cfg),
      .tmp_stb(tmp_stb), .tmp_val(tmp_val), .dev_restart(dev_restart),
      .output_off(output_off), .retry_locked(retry_locked), .oc_fault_r(oc_fault_r),
      .uc_fault_r(uc_fault_r), .ot_fault_r(ot_fault_r), .ut_fault_r(ut_fault_r),
      .status_r(status_r), .alert_n_r(alert_n_r));
   ctfm_host_model i_ctfm_host_model (.clk_sys(clk_sys), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clear_faults(clear_faults),
      .cmd_rdata_r(cmd_rdata_r), .cmd_rvalid_r(cmd_rvalid_r), .cmd_unsup_r(cmd_unsup_r));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict;
      if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic smp(input logic t, input logic [15:0] v, input logic b);
      @(posedge clk_sys);
      if (t) begin
         tmp_stb <= 1'b1;
         tmp_val <= v;
      end else begin
         cur_stb <= 1'b1;
         cur_val <= v;
         blank_done <= b;
      end
      @(posedge clk_sys);
      tmp_stb <= 1'b0;
      cur_stb <= 1'b0;
      #1;
   endtask
   task automatic restart;
      @(posedge clk_sys);
      dev_restart <= 1'b1;
      @(posedge clk_sys);
      dev_restart <= 1'b0;
      #1;
   endtask
   // A wait that runs out ends the run at once
   task automatic wait_off(input logic v, input int lim, output int k);
      k = 0;
      while (output_off !== v && k < lim) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      if (output_off !== v) begin
         chk("output_off", output_off, v);
         give_verdict();
      end
   endtask
   task automatic watch(input int lim, output int falls);
      logic prev;
      prev = output_off;
      falls = 0;
      repeat (lim) begin
         @(posedge clk_sys);
         #1;
         if (prev === 1'b1 && output_off === 1'b0) falls++;
         prev = output_off;
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      give_verdict();
   end
   initial begin
      {rst_n, cur_stb, blank_done, tmp_stb, dev_restart} = 5'h00;
      {cur_val, tmp_val} = 32'h0000_0000;
      sample_count_cfg = 4'h2;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk("alert_n", alert_n_r, 1'b1);
      foreach (rows[i]) begin
         ex = (rows[i].code == 8'h50 || rows[i].code == 8'h54) ? rows[i].wv & 16'h00ff : rows[i].wv;
         i_ctfm_host_model.rd(rows[i].code, rd_d, rd_ok);
         chk("reset value", {rd_ok, rd_d}, {1'b1, rows[i].rst});
         i_ctfm_host_model.wr(rows[i].code, rows[i].wv);
         i_ctfm_host_model.rd(rows[i].code, rd_d, rd_ok);
         chk("readback", {rd_ok, rd_d}, {1'b1, ex});
         i_ctfm_host_model.wr(rows[i].code, rows[i].rst);
      end
      i_ctfm_host_model.rd(8'h47, rd_d, rd_ok);
      chk("unmapped", {rd_ok, rd_d}, 17'h0003c);
      // Limit equal to the sample must not count; a blanked sample keeps the run
      smp(0, 16'h0210, 1);
      smp(0, 16'h0200, 1);
      smp(0, 16'h0210, 1);
      smp(0, 16'h0210, 0);
      chk("oc early", oc_fault_r, 1'b0);
      smp(0, 16'h0210, 1);
      chk("oc fault", {oc_fault_r, status_r[0], alert_n_r}, 3'h6);
      smp(0, 16'hfdf0, 1);
      smp(0, 16'hfdf0, 1);
      chk("uc fault", {uc_fault_r, status_r[1], oc_fault_r}, 3'h6);
      i_ctfm_host_model.wr(8'h46, 16'hf030);
      smp(0, 16'h00d0, 1);
      smp(0, 16'h00d0, 1);
      chk("decoded limit", oc_fault_r, 1'b1);
      smp(0, 16'h0000, 1);
      chk("sticky", status_r, 7'h03);
      i_ctfm_host_model.clear();
      chk("cleared", {status_r, alert_n_r}, 8'h01);
      smp(1, 16'h07e0, 0);
      chk("ot fault", {ot_fault_r, status_r}, 8'hd4);
      wait_off(1, 3, n);
      smp(1, 16'h06f0, 0);
      chk("ot hyst", ot_fault_r, 1'b1);
      smp(1, 16'h06d0, 0);
      chk("ot latched", {ot_fault_r, output_off, retry_locked}, 3'h3);
      restart();
      wait_off(0, 4, n);
      i_ctfm_host_model.clear();
      i_ctfm_host_model.wr(8'h54, 16'h00c0);
      smp(1, 16'hfc80, 0);
      chk("ut fault", {ut_fault_r, status_r}, 8'he8);
      wait_off(1, 3, n);
      smp(1, 16'hfcd0, 0);
      chk("ut hyst", ut_fault_r, 1'b1);
      smp(1, 16'hfcf0, 0);
      wait_off(0, 3, n);
      i_ctfm_host_model.clear();
      i_ctfm_host_model.wr(8'h50, 16'h0000);
      smp(1, 16'h07e0, 0);
      repeat (10) @(posedge clk_sys);
      #1;
      chk("ignore", {output_off, status_r[2]}, 2'h1);
      smp(1, 16'h0000, 0);
      i_ctfm_host_model.wr(8'h50, 16'h0042);
      smp(1, 16'h07e0, 0);
      wait_off(1, 40, n);
      chk("delay", (n >= UNIT && n <= 3 * UNIT + 2), 1'b1);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("no retry", retry_locked, 1'b1);
      smp(1, 16'h0000, 0);
      restart();
      i_ctfm_host_model.wr(8'h50, 16'h0089);
      smp(1, 16'h07e0, 0);
      wait_off(1, 3, n);
      watch(60, n);
      chk("one retry", {n[3:0], retry_locked}, 5'h03);
      i_ctfm_host_model.wr(8'h50, 16'h00b9);
      restart();
      watch(60, n);
      chk("endless", {n >= 3, retry_locked}, 2'h2);
      rst_n <= 1'b0;
      @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      i_ctfm_host_model.rd(8'h50, rd_d, rd_ok);
      chk("reset again", {rd_d, output_off}, 17'h00100);
      give_verdict();
   end
endmodule
